// [hw/ppid_pkg.sv]
// package: constants and carrier types for the process pid regulator
package ppid_pkg;
    localparam int unsigned DW            = 16;
    localparam logic [15:0] SCALE_LIMIT   = 16'h7FFF;
    // register offsets of the plain register port
    localparam logic [4:0] A_FB_MIN       = 5'h00;
    localparam logic [4:0] A_FB_MAX       = 5'h01;
    localparam logic [4:0] A_REF_MIN      = 5'h02;
    localparam logic [4:0] A_REF_MAX      = 5'h03;
    localparam logic [4:0] A_INT_REF      = 5'h04;
    localparam logic [4:0] A_PRESET2      = 5'h05;
    localparam logic [4:0] A_PRESET3      = 5'h06;
    localparam logic [4:0] A_PRESET4      = 5'h07;
    localparam logic [4:0] A_KP           = 5'h08;
    localparam logic [4:0] A_KI           = 5'h09;
    localparam logic [4:0] A_KD           = 5'h0A;
    localparam logic [4:0] A_CFG          = 5'h0B;
    localparam logic [4:0] A_ERR_WAKE     = 5'h0C;
    localparam logic [4:0] A_FB_WAKE      = 5'h0D;
    localparam logic [4:0] A_OUT_MIN      = 5'h0E;
    localparam logic [4:0] A_OUT_MAX      = 5'h0F;
    localparam logic [4:0] A_START_RAMP   = 5'h10;
    localparam logic [4:0] A_REF_RAMP     = 5'h11;
    localparam logic [4:0] A_ACC_RAMP     = 5'h12;
    localparam logic [4:0] A_DEC_RAMP     = 5'h13;
    localparam logic [4:0] A_FB_ALARM     = 5'h14;
    localparam logic [4:0] A_ERR_ALARM    = 5'h15;
    localparam logic [4:0] A_STATUS       = 5'h16;
    localparam logic [4:0] A_OUTPUT       = 5'h17;
    // cfg field positions
    localparam int unsigned CFG_FB_SRC    = 0;   // 3 bits, 0 = unassigned
    localparam int unsigned CFG_INT_EN    = 3;
    localparam int unsigned CFG_REVERSE   = 4;
    localparam int unsigned CFG_SEL_LO_EN = 5;
    localparam int unsigned CFG_PRED_SRC  = 6;   // 4 bits, 0 = none
    localparam int unsigned CFG_MAN_SRC   = 10;  // 3 bits
    localparam int unsigned CFG_EXT_CARD  = 13;
    localparam int unsigned CFG_ENC_CARD  = 14;
    localparam logic [15:0] CFG_RESET     = 16'h0000;
    localparam logic [15:0] GAIN_RESET    = 16'h0100;
    localparam logic [15:0] OUT_MAX_RESET = 16'h7FFF;
    // control tick: 1 ms at 125 MHz
    localparam int unsigned TICK_NS       = 1000000;
    localparam int unsigned CLK_NS        = 8;
    localparam int unsigned TICK_CYC      = TICK_NS / CLK_NS;
    localparam int unsigned SRC_N         = 11;

    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_START = 2'b01,
        ST_RUN   = 2'b10,
        ST_SLEEP = 2'b11
    } ppid_state_type;

    typedef struct packed {
        logic       manual;
        logic       sel_lo;
        logic       sel_hi;
        logic       int_short;
        logic       low_speed_stop;
    } ppid_li_type;

    typedef struct packed {
        logic       fb_alarm;
        logic       err_alarm;
        logic       active;
        logic       sleeping;
    } ppid_lo_type;
endpackage

// [hw/ppid_regulator.sv]
// process pid regulator with register port, ramps, sleep and alarms
// Behaviour
// - regulator idle until a feedback source is assigned, active afterwards
// - feedback from four analogs, frequency or encoder; options need cards
// - two select inputs choose channel a/internal, preset two, three, four
// - base reference is internal value or channel a per enable
// - optional predictive speed reference seeds motor speed on restart
// - accel/decel ramps act only on predictive reference changes
// - start ramp shapes output only on start and wake-up
// - reference ramp applies only when the reference changes
// - feedback min/max define sensor scale for all quantities
// - no scaling value above 32767
// - wake when error magnitude exceeds error wake threshold
// - reversal off raises speed on positive error, on lowers it
// - feedback wake above threshold, or below it when reversed
// - a logic input short-circuits integral action
// - configurable feedback alarm on a logic output
// - configurable error alarm on a logic output
// - manual input selects manual source instead of regulator
// - predictive source chosen among analogs, frequency, encoder, comms
// - output sums p, i and d terms with independent gains
//
// The strobed register port and the placing of the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none
module ppid_regulator
    import ppid_pkg::*;
#(
    parameter int unsigned TICK_CYCLES = TICK_CYC
)(
    input  wire logic                 clk_i,
    input  wire logic                 rst_n_i,
    input  wire logic [4:0]           addr_i,
    input  wire logic [15:0]          wdata_i,
    input  wire logic                 wr_i,
    input  wire logic                 rd_i,
    output logic      [15:0]          rdata_o,
    input  wire logic [SRC_N*16-1:0]  src_i,
    input  wire ppid_li_type          li_i,
    output logic      [15:0]          speed_ref_o,
    output ppid_lo_type               lo_o
);
    // sources: 0..3 analog, 4 pulse_frequency_input, 5 encoder_input,
    // 6 terminal, 7 modbus, 8 canopen, 9 comm card, 10 prog card
    logic [15:0] fb_min_q, fb_max_q, ref_min_q, ref_max_q;
    logic [15:0] int_ref_q, pre2_q, pre3_q, pre4_q;
    logic [15:0] kp_q, ki_q, kd_q, cfg_q, err_wake_q, fb_wake_q;
    logic [15:0] out_min_q, out_max_q, start_step_q, ref_step_q;
    logic [15:0] acc_step_q, dec_step_q, fb_alarm_q, err_alarm_q;
    logic [SRC_N*16-1:0] src_s1_q, src_s2_q;
    logic [4:0]          li_s1_q, li_s2_q;
    ppid_li_type         li;
    ppid_state_type      state_q;
    logic [31:0]         tick_cnt_q;
    logic                tick;
    logic signed [17:0]  ref_q, pred_q, err_q, out_q;
    logic signed [31:0]  integ_q;

    function automatic logic [15:0] pick(input logic [3:0] s,
                                         input logic [SRC_N*16-1:0] v);
        logic [15:0] r;
        r = 16'h0000;
        if (32'(s) < SRC_N)
            r = v[s*16 +: 16];
        return r;
    endfunction

    function automatic logic signed [17:0] sat(input logic signed [33:0] x,
                                               input logic [15:0] lo,
                                               input logic [15:0] hi);
        logic signed [17:0] r;
        r = x[17:0];
        if (x < $signed({18'h00000, lo}))
            r = $signed({2'b00, lo});
        else if (x > $signed({18'h00000, hi}))
            r = $signed({2'b00, hi});
        return r;
    endfunction

    function automatic logic signed [17:0] step_to(
        input logic signed [17:0] cur, input logic signed [17:0] tgt,
        input logic [15:0] up, input logic [15:0] dn);
        logic signed [17:0] r;
        r = tgt;
        if (tgt > cur && (tgt - cur) > $signed({2'b00, up}))
            r = cur + $signed({2'b00, up});
        else if (tgt < cur && (cur - tgt) > $signed({2'b00, dn}))
            r = cur - $signed({2'b00, dn});
        return r;
    endfunction

    function automatic logic [15:0] lim(input logic [15:0] v);
        return (v > SCALE_LIMIT) ? SCALE_LIMIT : v;
    endfunction

    // pins are asynchronous to clk_i: two flops before use
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            src_s1_q <= '0;
            src_s2_q <= '0;
            li_s1_q  <= 5'h00;
            li_s2_q  <= 5'h00;
        end
        else
        begin
            src_s1_q <= src_i;
            src_s2_q <= src_s1_q;
            li_s1_q  <= li_i;
            li_s2_q  <= li_s1_q;
        end
    end
    assign li = ppid_li_type'(li_s2_q);

    // register writes; scaling values clipped to the limit
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            fb_min_q <= 16'h0000;  fb_max_q <= OUT_MAX_RESET;
            ref_min_q <= 16'h0000; ref_max_q <= OUT_MAX_RESET;
            int_ref_q <= 16'h0000; pre2_q <= 16'h0000;
            pre3_q <= 16'h0000;    pre4_q <= 16'h0000;
            kp_q <= GAIN_RESET;    ki_q <= GAIN_RESET;
            kd_q <= 16'h0000;      cfg_q <= CFG_RESET;
            err_wake_q <= 16'h0000; fb_wake_q <= 16'h0000;
            out_min_q <= 16'h0000; out_max_q <= OUT_MAX_RESET;
            start_step_q <= 16'h0001; ref_step_q <= 16'h0001;
            acc_step_q <= 16'h0001; dec_step_q <= 16'h0001;
            fb_alarm_q <= OUT_MAX_RESET; err_alarm_q <= OUT_MAX_RESET;
        end
        else if (wr_i)
        begin
            case (addr_i)
                A_FB_MIN:     fb_min_q     <= lim(wdata_i);
                A_FB_MAX:     fb_max_q     <= lim(wdata_i);
                A_REF_MIN:    ref_min_q    <= lim(wdata_i);
                A_REF_MAX:    ref_max_q    <= lim(wdata_i);
                A_INT_REF:    int_ref_q    <= lim(wdata_i);
                A_PRESET2:    pre2_q       <= lim(wdata_i);
                A_PRESET3:    pre3_q       <= lim(wdata_i);
                A_PRESET4:    pre4_q       <= lim(wdata_i);
                A_KP:         kp_q         <= wdata_i;
                A_KI:         ki_q         <= wdata_i;
                A_KD:         kd_q         <= wdata_i;
                A_CFG:        cfg_q        <= wdata_i;
                A_ERR_WAKE:   err_wake_q   <= lim(wdata_i);
                A_FB_WAKE:    fb_wake_q    <= lim(wdata_i);
                A_OUT_MIN:    out_min_q    <= lim(wdata_i);
                A_OUT_MAX:    out_max_q    <= lim(wdata_i);
                A_START_RAMP: start_step_q <= wdata_i;
                A_REF_RAMP:   ref_step_q   <= wdata_i;
                A_ACC_RAMP:   acc_step_q   <= wdata_i;
                A_DEC_RAMP:   dec_step_q   <= wdata_i;
                A_FB_ALARM:   fb_alarm_q   <= lim(wdata_i);
                A_ERR_ALARM:  err_alarm_q  <= lim(wdata_i);
                default:      ;
            endcase
        end
    end

    // source decode and feasibility of optional inputs
    logic [2:0]  fb_src;
    logic        fb_ok;
    logic [15:0] fb_raw, fb_s, ref_tgt_raw, ref_tgt, man_ref, pred_ref;
    logic [3:0]  pred_src;
    always_comb
    begin
        fb_src = cfg_q[CFG_FB_SRC +: 3];
        // analog 3/4 and frequency need the extension, encoder its card
        case (fb_src)
            3'h1, 3'h2: fb_ok = 1'b1;
            3'h3, 3'h4, 3'h5: fb_ok = cfg_q[CFG_EXT_CARD];
            3'h6:       fb_ok = cfg_q[CFG_ENC_CARD];
            default:    fb_ok = 1'b0;
        endcase
        fb_raw  = pick({1'b0, fb_src - 3'h1}, src_s2_q);
        // clamp into the sensor range; all quantities share this scale
        fb_s    = (fb_raw < fb_min_q) ? fb_min_q :
                  (fb_raw > fb_max_q) ? fb_max_q : fb_raw;
        if (!cfg_q[CFG_SEL_LO_EN])
            ref_tgt_raw = cfg_q[CFG_INT_EN] ? int_ref_q
                                            : pick(4'h0, src_s2_q);
        else
        begin
            case ({li.sel_hi, li.sel_lo})
                2'b01:   ref_tgt_raw = pre2_q;
                2'b10:   ref_tgt_raw = pre3_q;
                2'b11:   ref_tgt_raw = pre4_q;
                default: ref_tgt_raw = cfg_q[CFG_INT_EN] ? int_ref_q
                                       : pick(4'h0, src_s2_q);
            endcase
        end
        ref_tgt = (ref_tgt_raw < ref_min_q) ? ref_min_q :
                  (ref_tgt_raw > ref_max_q) ? ref_max_q : ref_tgt_raw;
        man_ref  = pick({1'b0, cfg_q[CFG_MAN_SRC +: 3]}, src_s2_q);
        pred_src = cfg_q[CFG_PRED_SRC +: 4];
        pred_ref = (pred_src == 4'h0) ? 16'h0000
                   : pick(pred_src - 4'h1, src_s2_q);
    end

    // control tick divider
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            tick_cnt_q <= 32'h0;
        else if (tick_cnt_q >= TICK_CYCLES - 1)
            tick_cnt_q <= 32'h0;
        else
            tick_cnt_q <= tick_cnt_q + 32'h1;
    end
    assign tick = (tick_cnt_q >= TICK_CYCLES - 1);

    // wake conditions
    logic signed [17:0] err_mag;
    logic               wake;
    always_comb
    begin
        err_mag = err_q[17] ? -err_q : err_q;
        wake = (err_mag > $signed({2'b00, err_wake_q}))
             | (!cfg_q[CFG_REVERSE] ? (fb_s > fb_wake_q)
                                    : (fb_s < fb_wake_q));
    end

    // regulator state
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            state_q <= ST_IDLE;
        else
        begin
            case (state_q)
                ST_IDLE:  if (fb_ok) state_q <= ST_START;
                ST_START: if (!fb_ok) state_q <= ST_IDLE;
                          else if (tick && out_q == pred_q) state_q <= ST_RUN;
                ST_RUN:   if (!fb_ok) state_q <= ST_IDLE;
                          else if (li.low_speed_stop) state_q <= ST_SLEEP;
                ST_SLEEP: if (!fb_ok) state_q <= ST_IDLE;
                          else if (tick && wake) state_q <= ST_START;
                default:  state_q <= ST_IDLE;
            endcase
        end
    end

    // reference ramp: only moves when the target differs
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            ref_q <= 18'sh0;
        else if (state_q == ST_IDLE)
            ref_q <= $signed({2'b00, ref_tgt});
        else if (tick)
            ref_q <= step_to(ref_q, $signed({2'b00, ref_tgt}),
                             ref_step_q, ref_step_q);
    end

    // predictive reference: jumps on start, ramps on change
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            pred_q <= 18'sh0;
        else if (state_q != ST_RUN)
            pred_q <= $signed({2'b00, pred_ref});
        else if (tick)
            pred_q <= step_to(pred_q, $signed({2'b00, pred_ref}),
                              acc_step_q, dec_step_q);
    end

    // pid core; sign of error per correction direction
    logic signed [33:0] p_t, i_t, d_t, sum;
    logic signed [17:0] e_now;
    logic signed [31:0] integ_d;
    always_comb
    begin
        e_now = ref_q - $signed({2'b00, fb_s});
        if (cfg_q[CFG_REVERSE])
            e_now = -e_now;
        integ_d = integ_q + 32'(e_now * $signed({1'b0, ki_q}));
        if (li.int_short)
            integ_d = 32'sh0;
        // clamp the integrator in output units to stop wind-up
        if ((integ_d >>> 8) > $signed({16'h0000, out_max_q}))
            integ_d = $signed({8'h00, out_max_q, 8'h00});
        else if ((integ_d >>> 8) < -$signed({16'h0000, out_max_q}))
            integ_d = -$signed({8'h00, out_max_q, 8'h00});
        p_t = 34'(e_now * $signed({1'b0, kp_q})) >>> 8;
        i_t = 34'(integ_d) >>> 8;
        d_t = 34'((e_now - err_q) * $signed({1'b0, kd_q})) >>> 8;
        sum = 34'(pred_q) + p_t + i_t + d_t;
    end

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            err_q   <= 18'sh0;
            integ_q <= 32'sh0;
        end
        else if (state_q != ST_RUN || li.int_short)
        begin
            // held at zero so a restart never carries old error
            integ_q <= 32'sh0;
            if (tick)
                err_q <= e_now;
        end
        else if (tick)
        begin
            err_q   <= e_now;
            integ_q <= integ_d;
        end
    end

    // output: start ramp only on start and wake, else direct
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            out_q <= 18'sh0;
        else if (state_q == ST_IDLE || state_q == ST_SLEEP)
            out_q <= 18'sh0;
        else if (tick && state_q == ST_START)
            out_q <= step_to(out_q, pred_q, start_step_q,
                             start_step_q);
        else if (tick)
            out_q <= sat(sum, out_min_q, out_max_q);
    end

    // speed reference and logic outputs
    logic fb_alarm, err_alarm;
    assign fb_alarm  = fb_ok && (fb_s > fb_alarm_q);
    assign err_alarm = (state_q == ST_RUN)
                    && (err_mag > $signed({2'b00, err_alarm_q}));
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            speed_ref_o <= 16'h0000;
            lo_o        <= '0;
        end
        else
        begin
            speed_ref_o <= li.manual ? man_ref : out_q[15:0];
            lo_o.fb_alarm  <= fb_alarm;
            lo_o.err_alarm <= err_alarm;
            lo_o.active    <= (state_q != ST_IDLE);
            lo_o.sleeping  <= (state_q == ST_SLEEP);
        end
    end

    // read port: data one cycle after the strobe, zero elsewhere
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            rdata_o <= 16'h0000;
        else if (rd_i)
        begin
            case (addr_i)
                A_FB_MIN:     rdata_o <= fb_min_q;
                A_FB_MAX:     rdata_o <= fb_max_q;
                A_REF_MIN:    rdata_o <= ref_min_q;
                A_REF_MAX:    rdata_o <= ref_max_q;
                A_INT_REF:    rdata_o <= int_ref_q;
                A_PRESET2:    rdata_o <= pre2_q;
                A_PRESET3:    rdata_o <= pre3_q;
                A_PRESET4:    rdata_o <= pre4_q;
                A_KP:         rdata_o <= kp_q;
                A_KI:         rdata_o <= ki_q;
                A_KD:         rdata_o <= kd_q;
                A_CFG:        rdata_o <= cfg_q;
                A_ERR_WAKE:   rdata_o <= err_wake_q;
                A_FB_WAKE:    rdata_o <= fb_wake_q;
                A_OUT_MIN:    rdata_o <= out_min_q;
                A_OUT_MAX:    rdata_o <= out_max_q;
                A_START_RAMP: rdata_o <= start_step_q;
                A_REF_RAMP:   rdata_o <= ref_step_q;
                A_ACC_RAMP:   rdata_o <= acc_step_q;
                A_DEC_RAMP:   rdata_o <= dec_step_q;
                A_FB_ALARM:   rdata_o <= fb_alarm_q;
                A_ERR_ALARM:  rdata_o <= err_alarm_q;
                A_STATUS:     rdata_o <= {10'h000, fb_ok, fb_alarm,
                                          err_alarm, li.int_short,
                                          state_q};
                A_OUTPUT:     rdata_o <= out_q[15:0];
                default:      rdata_o <= 16'h0000;
            endcase
        end
        else
            rdata_o <= 16'h0000;
    end
endmodule
`default_nettype wire

// [verification/ppid_monitor.sv]
// port checker for the process pid regulator
`timescale 1ns/1ps
`default_nettype none
module ppid_monitor
    import ppid_pkg::*;
(
    input wire logic                clk_i,
    input wire logic                rst_n_i,
    input wire logic [4:0]          addr_i,
    input wire logic [15:0]         wdata_i,
    input wire logic                wr_i,
    input wire logic                rd_i,
    input wire logic [15:0]         rdata_o,
    input wire logic [SRC_N*16-1:0] src_i,
    input wire ppid_li_type         li_i,
    input wire logic [15:0]         speed_ref_o,
    input wire ppid_lo_type         lo_o
);
    logic [15:0] cfg_q;
    logic [2:0]  age_q;
    logic        cfg_wr;
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    assign cfg_wr = wr_i && addr_i == A_CFG;
    // cfg shadow; age lets the state settle before it is judged
    always_ff @(posedge clk_i or negedge rst_n_i)
        if (!rst_n_i)
            cfg_q <= CFG_RESET;
        else if (cfg_wr)
            cfg_q <= wdata_i;
    always_ff @(posedge clk_i or negedge rst_n_i)
        if (!rst_n_i)
            age_q <= 3'h0;
        else if (cfg_wr)
            age_q <= 3'h0;
        else if (age_q != 3'h7)
            age_q <= age_q + 3'h1;
    idle_unassigned_a: assert property (
        age_q > 3'h4 && cfg_q[2:0] == 3'h0 |-> !lo_o.active)
        else $error("active without feedback source");
    card_missing_a: assert property (
        age_q > 3'h4 && ((cfg_q[2:0] inside {[3'h3:3'h5]}
        && !cfg_q[CFG_EXT_CARD]) || (cfg_q[2:0] == 3'h6
        && !cfg_q[CFG_ENC_CARD])) |-> !lo_o.active)
        else $error("active with source card missing");
    scale_clip_a: assert property (
        rd_i && addr_i inside {[5'h00:5'h07], [5'h0C:5'h0F], 5'h14, 5'h15}
        |=> rdata_o <= SCALE_LIMIT)
        else $error("scaling value above limit");
    read_quiet_a: assert property (
        !rd_i || addr_i > A_OUTPUT |=> rdata_o == 16'h0000)
        else $error("read data without mapped read");
    short_seen_a: assert property (
        (li_i.int_short)[*4] ##0 (rd_i && addr_i == A_STATUS) |=> rdata_o[2])
        else $error("status misses integral short");
    short_clear_a: assert property (
        (!li_i.int_short)[*4] ##0 (rd_i && addr_i == A_STATUS)
        |=> !rdata_o[2])
        else $error("status shows stale integral short");
    err_run_a: assert property (
        $rose(lo_o.err_alarm) |-> lo_o.active)
        else $error("error alarm outside regulation");
    sleep_cause_a: assert property (
        (!li_i.low_speed_stop)[*8] |-> !$rose(lo_o.sleeping))
        else $error("sleep without low speed stop");
endmodule
bind ppid_regulator ppid_monitor u_monitor (.clk_i(clk_i),
    .rst_n_i(rst_n_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
    .rd_i(rd_i), .rdata_o(rdata_o), .src_i(src_i), .li_i(li_i),
    .speed_ref_o(speed_ref_o), .lo_o(lo_o));
`default_nettype wire

// [verification/ppid_plant.sv]
// process side model: sensor values seen by the regulator
`timescale 1ns/1ps
`default_nettype none
module ppid_plant
    import ppid_pkg::*;
(
    input  wire logic                clk_i,
    input  wire logic                rst_n_i,
    input  wire logic [SRC_N*16-1:0] set_i,
    output logic      [SRC_N*16-1:0] src_o
);
    // a transmitter saturates at full scale, it never wraps negative
    always_ff @(posedge clk_i or negedge rst_n_i)
        if (!rst_n_i)
            src_o <= '0;
        else
            for (int k = 0; k < SRC_N; k++)
                src_o[k*16 +: 16] <= set_i[k*16+15] ? SCALE_LIMIT
                    : set_i[k*16 +: 16];
endmodule
`default_nettype wire

// [verification/ppid_regulator_tb.sv]
// self-checking bench for the process pid regulator
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin err_count++; \
    $display("BAD t=%0t got %h exp %h", $time, (a), (b)); end end
module ppid_regulator_tb;
    import ppid_pkg::*;
    logic                clk_i = 1'b0;
    logic                rst_n_i = 1'b0;
    logic                wr_i = 1'b0;
    logic                rd_i = 1'b0;
    logic [4:0]          addr_i = 5'h00;
    logic [15:0]         wdata_i = 16'h0000;
    logic [15:0]         rdata_o, spd, lf, d;
    logic [SRC_N*16-1:0] set = '0, src;
    ppid_li_type         li = '0;
    ppid_lo_type         lo;
    int                  err_count = 0;
    int                  checked = 0;
    localparam logic [4:0]  RA [12] = '{5'h00, 5'h01, 5'h03, 5'h08, 5'h09,
        5'h0A, 5'h0B, 5'h0F, 5'h10, 5'h14, 5'h15, 5'h1F};
    localparam logic [15:0] RV [12] = '{16'h0000, 16'h7FFF, 16'h7FFF,
        16'h0100, 16'h0100, 16'h0000, 16'h0000, 16'h7FFF, 16'h0001,
        16'h7FFF, 16'h7FFF, 16'h0000};
    ppid_regulator #(.TICK_CYCLES(8)) DUT (.clk_i(clk_i), .rst_n_i(rst_n_i),
        .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
        .rdata_o(rdata_o), .src_i(src), .li_i(li), .speed_ref_o(spd),
        .lo_o(lo));
    ppid_plant u_plant (.clk_i(clk_i), .rst_n_i(rst_n_i), .set_i(set),
        .src_o(src));
    always #4 clk_i = ~clk_i;
    function automatic logic [15:0] nx(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    function automatic logic [15:0] clip(input logic [15:0] v);
        return v > SCALE_LIMIT ? SCALE_LIMIT : v;
    endfunction
    function automatic logic act(input int s, input logic e, input logic n);
        return s inside {1, 2} || (s inside {[3:5]} && e) || (s == 6 && n);
    endfunction
    // wide ramps keep restarts short; reference range inside sensor range
    function automatic logic [15:0] dflt(input int a);
        case (a) inside
            1, 3, 12, 13, 15, [16:19], 20, 21: return 16'h7FFF;
            4: return 16'h6000;
            8, 9: return 16'h0100;
            default: return 16'h0000;
        endcase
    endfunction
    // p only, no integral: steady output is reference minus 0x1000 feedback
    function automatic logic [15:0] pre_exp(input int c);
        case (c)
            1: return 16'h2000;
            2: return 16'h3000;
            3: return 16'h4000;
            5: return 16'h0000;
            default: return 16'h5000;
        endcase
    endfunction
    task automatic wr(input logic [4:0] a, input logic [15:0] v);
        addr_i <= a;
        wdata_i <= v;
        wr_i <= 1'b1;
        @(posedge clk_i);
        wr_i <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic rd(input logic [4:0] a, output logic [15:0] v);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clk_i);
        rd_i <= 1'b0;
        @(posedge clk_i);
        v = rdata_o;
    endtask
    task automatic wlo(input int b, input logic x, input int n);
        for (int k = 0; k < n && lo[b] !== x; k++)
            @(posedge clk_i);
        `CHK(lo[b], x)
    endtask
    task automatic nap(input logic [4:0] a, input logic [15:0] v);
        li.low_speed_stop <= 1'b1;
        wlo(0, 1'b1, 200);
        li.low_speed_stop <= 1'b0;
        repeat (60) @(posedge clk_i);
        `CHK(lo.sleeping, 1'b1)
        wr(a, v);
        wlo(0, 1'b0, 200);
    endtask
    task automatic give_verdict();
        $display("checks %0d errors %0d", checked, err_count);
        if (err_count == 0 && checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    initial
    begin
        lf = 16'hC334;
        repeat (8) @(posedge clk_i);
        rst_n_i <= 1'b1;
        @(posedge clk_i);
        for (int i = 0; i < 12; i++)
        begin
            rd(RA[i], d);
            `CHK(d, RV[i])
        end
        for (int i = 0; i < 22; i++)
        begin
            lf = nx(lf);
            if (i == 11)
                continue;
            wr(i[4:0], lf);
            rd(i[4:0], d);
            `CHK(d, i inside {[8:10], [16:19]} ? lf : clip(lf))
        end
        for (int i = 0; i < 22; i++)
            wr(i[4:0], dflt(i));
        for (int s = 0; s < 7; s++)
        begin
            lf = nx(lf);
            wr(A_CFG, {1'b0, lf[1:0], 10'h000, s[2:0]});
            repeat (20) @(posedge clk_i);
            `CHK(lo.active, act(s, lf[0], lf[1]))
        end
        li.manual <= 1'b1;
        for (int m = 0; m < 6; m++)
        begin
            lf = nx(lf);
            set[m*16 +: 16] <= lf;
            wr(A_CFG, {3'h0, m[2:0], 10'h001});
            repeat (30) @(posedge clk_i);
            `CHK(spd, clip(lf))
        end
        li.manual <= 1'b0;
        set[15:0] <= 16'h1000;
        wr(A_CFG, 16'h0009);
        repeat (300) @(posedge clk_i);
        `CHK(spd > 16'h0000, 1'b1)
        wr(A_OUT_MAX, 16'h1234);
        repeat (100) @(posedge clk_i);
        `CHK(spd, 16'h1234)
        wr(A_OUT_MAX, 16'h7FFF);
        wr(A_ERR_ALARM, 16'h0010);
        wlo(2, 1'b1, 200);
        wr(A_FB_ALARM, 16'h0800);
        wlo(3, 1'b1, 60);
        rd(A_STATUS, d);
        `CHK(d[2], 1'b0)
        li.int_short <= 1'b1;
        repeat (6) @(posedge clk_i);
        rd(A_STATUS, d);
        `CHK(d[2], 1'b1)
        li.int_short <= 1'b0;
        wr(A_CFG, 16'h0019);
        for (int k = 0; k < 400 && spd !== 16'h0000; k++)
            @(posedge clk_i);
        `CHK(spd, 16'h0000)
        wr(A_FB_WAKE, 16'h0000);
        nap(A_FB_WAKE, 16'h2000);
        wr(A_CFG, 16'h0009);
        nap(A_ERR_WAKE, 16'h0100);
        wr(A_ERR_WAKE, 16'h7FFF);
        nap(A_FB_WAKE, 16'h0800);
        wr(A_KI, 16'h0000);
        wr(A_PRESET2, 16'h3000);
        wr(A_PRESET3, 16'h4000);
        wr(A_PRESET4, 16'h5000);
        // idle once so the integrator starts from zero
        wr(A_CFG, 16'h0000);
        for (int c = 0; c < 6; c++)
        begin
            {li.sel_hi, li.sel_lo} <= c[1:0] ^ {2{c[2]}};
            wr(A_CFG, c == 5 ? 16'h0001 : c == 4 ? 16'h0009 : 16'h0029);
            repeat (40) @(posedge clk_i);
            `CHK(spd, pre_exp(c))
        end
        wr(A_CFG, 16'h0049);
        repeat (40) @(posedge clk_i);
        `CHK(spd, 16'h6000)
        give_verdict();
    end
    initial
    begin
        #160000;
        err_count++;
        give_verdict();
    end
endmodule
`default_nettype wire
